// *** hdl/gcnt_top.sv ***
// Gated encoder counter with APB registers, latch and compare output.
// Assumes pins are asynchronous to pclk and an APB master on pclk.
//
// Function
// - Count only while the internal gate is open.
// - Hardware gate evaluation can be disabled, leaving the software gate alone.
// - Rising edge on the hardware gate input opens the hardware gate.
// - Falling edge on the hardware gate input closes the hardware gate.
// - Software gate follows the software gate request bit.
// - Count readable on the count value output and at its register.
// - Quadrature encoder tracks give count and direction.
// - Pulse input A counts, input B sets direction.
// - Encoder evaluation selectable as single, double or quadruple.
// - Direction on input B can be inverted.
// - Physical inputs are mapped to counter functions by configuration.
// - Rising latch edge copies the count into a readable holding register.
// - Counter owns one output with a configurable compare mode.
// - No-compare mode leaves the output to software.
// - Greater-or-equal mode sets output while count is at least compare value.
// - Less-or-equal mode sets output while count is at most compare value.
`timescale 1ns/10ps
module gcnt_top
  import gcnt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pin_in,
  output logic [31:0] count_value,
  output logic cmp_out,
  output logic gate_open
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic sel_pin(input logic [3:0] p, input logic [1:0] idx);
    sel_pin = p[idx];
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [3:0] pin_s;
  logic [7:0] ctrl_r;
  logic [7:0] map_r;
  logic [31:0] cmp_r;
  logic [31:0] jobdata_r;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] latch_r;
  logic hardware_gate_r;
  logic gate_pin_d_r;
  logic latch_pin_d_r;
  logic job_done_r;
  logic [1:0] job_code_r;
  gcnt_job_st_t job_st_r;

  gcnt_dec_if dif ();

  gcnt_sync #(.W(GCNT_NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pin_in),
    .dout(pin_s)
  );

  gcnt_dec u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .d(dif)
  );

  // ****************************************
  // Input mapping and control fields
  // ****************************************
  wire pin_a = sel_pin(pin_s, map_r[GCNT_MAP_A +: 2]);
  wire pin_b = sel_pin(pin_s, map_r[GCNT_MAP_B +: 2]);
  wire gate_pin = sel_pin(pin_s, map_r[GCNT_MAP_GATE +: 2]);
  wire latch_pin = sel_pin(pin_s, map_r[GCNT_MAP_LATCH +: 2]);
  wire swg = ctrl_r[GCNT_CTRL_SWG];
  wire hw_en = ctrl_r[GCNT_CTRL_HWEN];
  wire [1:0] cmp_mode = ctrl_r[GCNT_CTRL_CMP +: 2];

  assign dif.a = pin_a;
  assign dif.b = pin_b;
  assign dif.inv = ctrl_r[GCNT_CTRL_INV];
  assign dif.mode = gcnt_inmode_t'(ctrl_r[GCNT_CTRL_MODE +: 2]);

  // ****************************************
  // Gates
  // ****************************************
  wire gate_rise = gate_pin & ~gate_pin_d_r;
  wire gate_fall = ~gate_pin & gate_pin_d_r;
  wire gate_int = hw_en ? (hardware_gate_r & swg) : swg;
  wire latch_rise = latch_pin & ~latch_pin_d_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire addr_ok = hit(paddr, GCNT_OFS_CTRL) | hit(paddr, GCNT_OFS_MAP) |
                 hit(paddr, GCNT_OFS_CMP) | hit(paddr, GCNT_OFS_COUNT) |
                 hit(paddr, GCNT_OFS_LATCH) | hit(paddr, GCNT_OFS_JOB) |
                 hit(paddr, GCNT_OFS_JOBDATA) | hit(paddr, GCNT_OFS_STAT);
  wire wr_ctrl = wr_en & hit(paddr, GCNT_OFS_CTRL);
  wire wr_map = wr_en & hit(paddr, GCNT_OFS_MAP);
  wire wr_cmp = wr_en & hit(paddr, GCNT_OFS_CMP);
  wire wr_jobdata = wr_en & hit(paddr, GCNT_OFS_JOBDATA);
  wire wr_job = wr_en & hit(paddr, GCNT_OFS_JOB);
  wire job_start = wr_job & job_done_r & (pwdata[1:0] != 2'h0);
  wire job_apply = (job_st_r == GCNT_JOB_RUN);
  wire [31:0] stat_word = {26'h0, dif.up, hw_en, gate_int, hardware_gate_r, swg, job_done_r};
  wire [31:0] job_word = {23'h0, job_done_r, 6'h0, job_code_r};
  wire [31:0] rd_mux =
    hit(paddr, GCNT_OFS_CTRL) ? {24'h0, ctrl_r} :
    hit(paddr, GCNT_OFS_MAP) ? {24'h0, map_r} :
    hit(paddr, GCNT_OFS_CMP) ? cmp_r :
    hit(paddr, GCNT_OFS_COUNT) ? count_r :
    hit(paddr, GCNT_OFS_LATCH) ? latch_r :
    hit(paddr, GCNT_OFS_JOB) ? job_word :
    hit(paddr, GCNT_OFS_JOBDATA) ? jobdata_r :
    hit(paddr, GCNT_OFS_STAT) ? stat_word : 32'h0000_0000;

  // ****************************************
  // Count and compare
  // ****************************************
  wire load_cnt = job_apply & (job_code_r == GCNT_JOB_LOAD_CNT);
  wire load_cmp = job_apply & (job_code_r == GCNT_JOB_LOAD_CMP);
  wire do_step = gate_int & dif.step;
  wire ge_hit = $signed(count_r) >= $signed(cmp_r);
  wire le_hit = $signed(count_r) <= $signed(cmp_r);
  wire cmp_nxt = (cmp_mode == GCNT_CMP_GE) ? ge_hit :
                 (cmp_mode == GCNT_CMP_LE) ? le_hit :
                 (cmp_mode == GCNT_CMP_NONE) ? ctrl_r[GCNT_CTRL_SWOUT] : 1'b0;

  always_comb
  begin
    count_nxt = count_r;
    if (load_cnt)
      count_nxt = jobdata_r;
    else if (do_step)
      count_nxt = dif.up ? count_r + 32'h1 : count_r - 32'h1;
  end

  // ****************************************
  // APB slave
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      prdata <= setup ? rd_mux : prdata;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= GCNT_CTRL_RST;
      map_r <= GCNT_MAP_RST;
      jobdata_r <= GCNT_CMP_RST;
    end
    else
    begin
      ctrl_r <= wr_ctrl ? pwdata[7:0] : ctrl_r;
      map_r <= wr_map ? pwdata[7:0] : map_r;
      jobdata_r <= wr_jobdata ? pwdata : jobdata_r;
    end
  end

  // ****************************************
  // Job handshake
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      job_st_r <= GCNT_JOB_IDLE;
      job_done_r <= 1'b1;
      job_code_r <= 2'h0;
    end
    else
    begin
      case (job_st_r)
        GCNT_JOB_IDLE:
        begin
          if (job_start)
          begin
            job_st_r <= GCNT_JOB_RUN;
            job_done_r <= 1'b0;
            job_code_r <= pwdata[1:0];
          end
        end
        GCNT_JOB_RUN:
        begin
          job_st_r <= GCNT_JOB_IDLE;
          job_done_r <= 1'b1;
        end
        default:
        begin
          job_st_r <= GCNT_JOB_IDLE;
          job_done_r <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Counter datapath
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= GCNT_CNT_RST;
      cmp_r <= GCNT_CMP_RST;
      latch_r <= GCNT_CNT_RST;
      hardware_gate_r <= 1'b0;
      gate_pin_d_r <= 1'b0;
      latch_pin_d_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      cmp_r <= load_cmp ? jobdata_r : (wr_cmp ? pwdata : cmp_r);
      latch_r <= latch_rise ? count_r : latch_r;
      gate_pin_d_r <= gate_pin;
      latch_pin_d_r <= latch_pin;
      if (gate_rise)
        hardware_gate_r <= 1'b1;
      else if (gate_fall)
        hardware_gate_r <= 1'b0;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_value <= GCNT_CNT_RST;
      cmp_out <= 1'b0;
      gate_open <= 1'b0;
    end
    else
    begin
      count_value <= count_nxt;
      cmp_out <= cmp_nxt;
      gate_open <= gate_int;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  gate_closed_hold_a: assert property ((!gate_int && !job_apply) |=> $stable(count_r))
    else $error("count moved with the gate closed");
  sw_only_gate_a: assert property (
    (!hw_en && swg && dif.step && !job_apply) |=> (count_r != $past(count_r)))
    else $error("software gate alone did not let the count move");
  hw_open_edge_a: assert property ((gate_pin && !gate_pin_d_r) |=> hardware_gate_r)
    else $error("rising gate edge did not open the hardware gate");
  hw_close_edge_a: assert property ((!gate_pin && gate_pin_d_r) |=> !hardware_gate_r)
    else $error("falling gate edge did not close the hardware gate");
  software_gate_follow_a: assert property ((!hw_en ##1 !hw_en) |-> (gate_open == $past(swg)))
    else $error("gate did not follow the software request");
  count_read_a: assert property (
    (setup && hit(paddr, GCNT_OFS_COUNT)) |=> (prdata == $past(count_r) && count_value == count_r))
    else $error("count read back wrong");
  count_up_a: assert property ((do_step && dif.up && !job_apply) |=>
    (count_r == $past(count_r) + 32'h1))
    else $error("up step did not add one");
  latch_capture_a: assert property ((latch_pin && !latch_pin_d_r) |=>
    (latch_r == $past(count_r)))
    else $error("latch edge did not capture the count");
  cmp_none_sw_a: assert property ((cmp_mode == GCNT_CMP_NONE) |=>
    (cmp_out == $past(ctrl_r[GCNT_CTRL_SWOUT])))
    else $error("no-compare output not under software");
  cmp_ge_a: assert property ((cmp_mode == GCNT_CMP_GE) |=>
    (cmp_out == ($signed($past(count_r)) >= $signed($past(cmp_r)))))
    else $error("greater-or-equal output wrong");
  cmp_le_a: assert property ((cmp_mode == GCNT_CMP_LE) |=>
    (cmp_out == ($signed($past(count_r)) <= $signed($past(cmp_r)))))
    else $error("less-or-equal output wrong");
  both_gates_a: assert property ((hw_en && !hardware_gate_r && !job_apply) |=> $stable(count_r))
    else $error("count moved with hardware gate closed");
  job_done_a: assert property ((job_start) |=> (!job_done_r ##1 job_done_r))
    else $error("job did not complete in two cycles");
  map_select_a: assert property ($stable(map_r) && map_r[GCNT_MAP_LATCH +: 2] == 2'h0 &&
    pin_s[0] && !latch_pin_d_r |=> (latch_r == $past(count_r)))
    else $error("latch input mapping not applied");
endmodule

// *** pkg/gcnt_pkg.sv ***
// Constants and types of the gated encoder counter.
// Assumes a single 125 MHz APB clock domain.
package gcnt_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] GCNT_OFS_CTRL = 8'h00;
  localparam logic [7:0] GCNT_OFS_MAP = 8'h04;
  localparam logic [7:0] GCNT_OFS_CMP = 8'h08;
  localparam logic [7:0] GCNT_OFS_COUNT = 8'h0c;
  localparam logic [7:0] GCNT_OFS_LATCH = 8'h10;
  localparam logic [7:0] GCNT_OFS_JOB = 8'h14;
  localparam logic [7:0] GCNT_OFS_JOBDATA = 8'h18;
  localparam logic [7:0] GCNT_OFS_STAT = 8'h1c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GCNT_CTRL_SWG = 0;
  localparam int GCNT_CTRL_HWEN = 1;
  localparam int GCNT_CTRL_MODE = 2;
  localparam int GCNT_CTRL_INV = 4;
  localparam int GCNT_CTRL_CMP = 5;
  localparam int GCNT_CTRL_SWOUT = 7;
  localparam int GCNT_MAP_A = 0;
  localparam int GCNT_MAP_B = 2;
  localparam int GCNT_MAP_GATE = 4;
  localparam int GCNT_MAP_LATCH = 6;
  localparam int GCNT_JOB_DONE = 8;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] GCNT_CTRL_RST = 8'h00;
  localparam logic [7:0] GCNT_MAP_RST = 8'he4;
  localparam logic [31:0] GCNT_CMP_RST = 32'h0000_0000;
  localparam logic [31:0] GCNT_CNT_RST = 32'h0000_0000;
  localparam logic [1:0] GCNT_JOB_LOAD_CNT = 2'h1;
  localparam logic [1:0] GCNT_JOB_LOAD_CMP = 2'h2;
  localparam int GCNT_NPIN = 4;

  typedef enum logic [1:0] {GCNT_IN_PULSE, GCNT_IN_X1, GCNT_IN_X2, GCNT_IN_X4} gcnt_inmode_t;
  typedef enum logic [1:0] {GCNT_CMP_NONE, GCNT_CMP_GE, GCNT_CMP_LE, GCNT_CMP_RSV} gcnt_cmp_t;
  typedef enum logic {GCNT_JOB_IDLE, GCNT_JOB_RUN} gcnt_job_st_t;

endpackage

// *** pkg/gcnt_dec_if.sv ***
// Interface between the counter core and its track decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface gcnt_dec_if;
  import gcnt_pkg::*;
  logic a;
  logic b;
  logic inv;
  gcnt_inmode_t mode;
  logic step;
  logic up;
  modport ctl (output a, output b, output inv, output mode, input step, input up);
  modport dec (input a, input b, input inv, input mode, output step, output up);
endinterface

// *** hdl/gcnt_sync.sv ***
// Two-stage synchroniser for the counter's physical inputs.
// Assumes asynchronous pins and one clock.
`timescale 1ns/10ps
module gcnt_sync
  import gcnt_pkg::*;
#(
  parameter int W = GCNT_NPIN
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // ****************************************
  // One pair of flops per pin
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_r[i] <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          meta_r[i] <= din[i];
          dout[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// *** hdl/gcnt_dec.sv ***
// Track decoder: pulse plus direction, or quadrature with 1, 2 or 4 edges.
// Assumes synchronised tracks; step and up are combinational, one cycle wide.
`timescale 1ns/10ps
module gcnt_dec
  import gcnt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  gcnt_dec_if.dec d
);
  logic a_d_r;
  logic b_d_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
    end
    else
    begin
      a_d_r <= d.a;
      b_d_r <= d.b;
    end
  end

  // ****************************************
  // Edge and direction decode
  // ****************************************
  wire a_rise = d.a & ~a_d_r;
  wire a_edge = d.a ^ a_d_r;
  wire b_edge = d.b ^ b_d_r;
  wire dir_a = d.a ^ d.b;
  wire dir_b = ~(d.a ^ d.b);
  wire pulse_mode = (d.mode == GCNT_IN_PULSE);
  wire step_pulse = a_rise;
  wire up_pulse = ~d.b;
  wire step_x1 = a_rise;
  wire step_x2 = a_edge;
  wire step_x4 = a_edge | b_edge;
  wire up_quad = a_edge ? dir_a : dir_b;
  wire up_raw = pulse_mode ? up_pulse : up_quad;

  assign d.step = pulse_mode ? step_pulse :
                  (d.mode == GCNT_IN_X1) ? step_x1 :
                  (d.mode == GCNT_IN_X2) ? step_x2 : step_x4;
  assign d.up = up_raw ^ d.inv;

  // ****************************************
  // Checks
  // ****************************************
  pulse_dir_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pulse_mode && a_rise) |-> (d.step && (d.up == (~d.b ^ d.inv))))
    else $error("pulse edge did not step with B direction");
  quad4_b_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    (d.mode == GCNT_IN_X4 && !a_edge && b_edge) |-> d.step)
    else $error("quadruple evaluation missed a B edge");
  quad1_no_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (d.mode == GCNT_IN_X1 && !d.a && a_d_r) |-> !d.step)
    else $error("single evaluation stepped on falling A");
  quad_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!pulse_mode && d.a && !a_d_r && !d.b && !b_edge) |-> (d.up == !d.inv))
    else $error("A leading B did not count up");
endmodule

// *** test/gcnt_src.sv ***
// Behavioural pulse, direction and quadrature source on the counter's pins.
// Assumes the bench calls its tasks from one process, clocked by pclk.
`timescale 1ns/10ps
module gcnt_src
(
  input wire logic pclk,
  output logic [3:0] pins
);
  // ****************************************
  // Pin stepping
  // ****************************************
  initial pins = 4'h0;

  // Holds one pin level for ph clocks, changed just after an edge
  task automatic set(input int idx, input logic v, input int ph);
    @(posedge pclk);
    pins[idx] <= v;
    repeat (ph) @(posedge pclk);
  endtask

  // Count pulses on one pin, high and low for ph+1 clocks each
  task automatic pulse(input int idx, input int n, input int ph);
    repeat (n)
    begin
      set(idx, 1'b1, ph);
      set(idx, 1'b0, ph);
    end
  endtask

  // Full quadrature cycles on pins 0 and 1; fwd means track A leads B
  task automatic quad(input int cyc, input bit fwd, input int ph);
    repeat (cyc)
    begin
      set(fwd ? 0 : 1, 1'b1, ph);
      set(fwd ? 1 : 0, 1'b1, ph);
      set(fwd ? 0 : 1, 1'b0, ph);
      set(fwd ? 1 : 0, 1'b0, ph);
    end
  endtask
endmodule

// *** test/test_gated_encoder_counter.sv ***
// Self-checking bench of the gated encoder counter over APB.
// Assumes gcnt_top with default pin map and the gcnt_src pin model.
`timescale 1ns/10ps
module test_gated_encoder_counter;
  import gcnt_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pin_in;
  logic [31:0] count_value;
  logic cmp_out;
  logic gate_open;
  int err_count;
  int total_checks;
  logic [31:0] q;
  logic e;

  gcnt_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .count_value(count_value), .cmp_out(cmp_out),
    .gate_open(gate_open));
  gcnt_src src_u (.pclk(pclk), .pins(pin_in));

  // ****************************************
  // Clock, reporting and bus tasks
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Loads count or compare value, then waits for the job to finish
  task automatic job(input logic [1:0] code, input logic [31:0] d);
    int n;
    wr(GCNT_OFS_JOBDATA, d);
    wr(GCNT_OFS_JOB, {30'h0, code});
    n = 0;
    do
    begin
      xfer(1'b0, GCNT_OFS_JOB, 32'h0);
      n++;
    end
    while (q[GCNT_JOB_DONE] !== 1'b1 && n < 20);
    if (q[GCNT_JOB_DONE] !== 1'b1)
    begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic cnt(input logic [31:0] exp);
    idle(5);
    chk(count_value, exp);
    rd(GCNT_OFS_COUNT, exp);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_count = 0;
    total_checks = 0;
    presetn = 1'b0;
    idle(20);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(GCNT_OFS_CTRL, 32'h0);
    rd(GCNT_OFS_MAP, 32'he4);
    rd(GCNT_OFS_CMP, 32'h0);
    rd(GCNT_OFS_JOB, 32'h100);
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(GCNT_OFS_COUNT, 32'h55);
    rd(GCNT_OFS_COUNT, 32'h0);
    $display("test registers done");
    src_u.pulse(0, 2, 3);
    cnt(32'h0);
    wr(GCNT_OFS_CTRL, 32'h01);
    src_u.pulse(0, 5, 3);
    cnt(32'h5);
    src_u.set(1, 1'b1, 3);
    src_u.pulse(0, 3, 2);
    cnt(32'h2);
    wr(GCNT_OFS_CTRL, 32'h11);
    src_u.pulse(0, 2, 3);
    cnt(32'h4);
    src_u.set(1, 1'b0, 3);
    wr(GCNT_OFS_CTRL, 32'h00);
    src_u.pulse(0, 2, 3);
    cnt(32'h4);
    $display("test pulse done");
    for (int m = 1; m < 4; m++)
    begin
      wr(GCNT_OFS_CTRL, 32'h01 | (m << 2));
      job(GCNT_JOB_LOAD_CNT, 32'h0);
      src_u.quad(2, 1'b1, 3);
      cnt(32'h2 << (m - 1));
      src_u.quad(1, 1'b0, 3);
      cnt(32'h1 << (m - 1));
    end
    $display("test quadrature done");
    wr(GCNT_OFS_CTRL, 32'h03);
    job(GCNT_JOB_LOAD_CNT, 32'h0);
    src_u.pulse(0, 3, 3);
    cnt(32'h0);
    chk({31'h0, gate_open}, 32'h0);
    src_u.set(2, 1'b1, 5);
    chk({31'h0, gate_open}, 32'h1);
    src_u.pulse(0, 3, 3);
    cnt(32'h3);
    src_u.set(2, 1'b0, 5);
    chk({31'h0, gate_open}, 32'h0);
    src_u.pulse(0, 2, 3);
    cnt(32'h3);
    wr(GCNT_OFS_CTRL, 32'h01);
    src_u.pulse(0, 2, 3);
    cnt(32'h5);
    chk({31'h0, gate_open}, 32'h1);
    $display("test gate done");
    src_u.pulse(3, 1, 3);
    idle(5);
    rd(GCNT_OFS_LATCH, 32'h5);
    src_u.pulse(0, 2, 3);
    wr(GCNT_OFS_LATCH, 32'h0);
    rd(GCNT_OFS_LATCH, 32'h5);
    wr(GCNT_OFS_CTRL, 32'h00);
    wr(GCNT_OFS_MAP, 32'h23);
    wr(GCNT_OFS_CTRL, 32'h01);
    src_u.pulse(3, 3, 3);
    cnt(32'ha);
    src_u.pulse(0, 1, 3);
    idle(5);
    rd(GCNT_OFS_LATCH, 32'ha);
    wr(GCNT_OFS_CTRL, 32'h00);
    wr(GCNT_OFS_MAP, 32'he4);
    $display("test latch and map done");
    job(GCNT_JOB_LOAD_CMP, 32'ha);
    rd(GCNT_OFS_CMP, 32'ha);
    wr(GCNT_OFS_CTRL, 32'h21);
    idle(3);
    chk({31'h0, cmp_out}, 32'h1);
    src_u.set(1, 1'b1, 3);
    src_u.pulse(0, 1, 3);
    cnt(32'h9);
    chk({31'h0, cmp_out}, 32'h0);
    wr(GCNT_OFS_CTRL, 32'h41);
    idle(3);
    chk({31'h0, cmp_out}, 32'h1);
    src_u.set(1, 1'b0, 3);
    src_u.pulse(0, 2, 3);
    cnt(32'hb);
    chk({31'h0, cmp_out}, 32'h0);
    job(GCNT_JOB_LOAD_CNT, 32'hffff_ffff);
    idle(3);
    chk({31'h0, cmp_out}, 32'h1);
    wr(GCNT_OFS_CTRL, 32'h81);
    idle(3);
    chk({31'h0, cmp_out}, 32'h1);
    wr(GCNT_OFS_CTRL, 32'he1);
    idle(3);
    chk({31'h0, cmp_out}, 32'h0);
    wr(GCNT_OFS_CTRL, 32'h01);
    idle(3);
    chk({31'h0, cmp_out}, 32'h0);
    $display("test compare done");
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    idle(2);
    chk(count_value, 32'h0);
    chk({31'h0, cmp_out}, 32'h0);
    rd(GCNT_OFS_JOB, 32'h100);
    rd(GCNT_OFS_COUNT, 32'h0);
    rd(GCNT_OFS_MAP, 32'he4);
    $display("test reset done");
    complete_run();
  end
endmodule
